// *** core/ufc_pkg.sv ***
/*
 Shared constants and state type for both ends of the flow-controlled
 serial link. Assumes a 50 MHz system clock on each end.
*/
package ufc_pkg;
	localparam int CLK_HZ     = 50_000_000;
	localparam int BAUD       = 115_200;
	localparam int BIT_CYC    = CLK_HZ / BAUD;
	localparam int HALF_CYC   = BIT_CYC / 2;
	localparam int CNT_W      = $clog2(BIT_CYC);
	localparam int DATA_BITS  = 8;
	localparam int IDX_W      = $clog2(DATA_BITS);
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_WIDTH = DATA_BITS + 1;
	// Free slots kept when the request line drops
	localparam int RTS_SLACK  = 2;

	localparam logic [CNT_W-1:0] BIT_M1   = CNT_W'(BIT_CYC - 1);
	localparam logic [CNT_W-1:0] HALF_M1  = CNT_W'(HALF_CYC - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);
	localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(DATA_BITS - 1);
	localparam logic [IDX_W-1:0] IDX_ZERO = IDX_W'(0);
	localparam logic [$clog2(FIFO_DEPTH):0] RTS_LEVEL =
		($clog2(FIFO_DEPTH)+1)'(FIFO_DEPTH - RTS_SLACK);

	typedef enum logic [2:0]
	{
		UFC_IDLE,
		UFC_START,
		UFC_DATA,
		UFC_PAR,
		UFC_STOP
	} ufc_state_t;
endpackage : ufc_pkg

// *** core/ufc_link_if.sv ***
/*
 Four-wire link between device end and host end.
 Assumes the testbench instantiates it once and joins both ends.
*/
`timescale 1ns/1ps
interface ufc_link_if;
	logic dev_txd;
	logic rts_n;
	logic host_txd;
	logic host_txd_oe;
	logic cts_n;
	logic cts_n_oe;
	wire  rx_line;
	wire  cts_line;

	// Undriven receive line reads idle high
	assign rx_line  = host_txd_oe ? host_txd : 1'b1; // (RL7)
	// Undriven clear line reads asserted
	assign cts_line = cts_n_oe ? cts_n : 1'b0; // (RL9)

	modport dev
	(
		output dev_txd,
		output rts_n,
		input  rx_line,
		input  cts_line
	);

	modport host
	(
		output host_txd,
		output host_txd_oe,
		output cts_n,
		output cts_n_oe,
		input  dev_txd,
		input  rts_n
	);
endinterface : ufc_link_if

// *** core/ufc_device.sv ***
/*
 Device end of the serial link: transmitter, receiver, receive FIFO
 and hardware request/clear handshake.
 Assumes a 50 MHz clock, synchronous reset, and a host that stops
 sending within RTS_SLACK characters of request going high.
*/
// Functional notes
// (RL1) Full-duplex async link, hardware handshake
// (RL2) Optional parity check on received characters
// (RL3) Request is output, clear is input, active-low
// (RL4) Both data lines idle high
// (RL5) Low handshake level means asserted
// (RL6) Transmit line driven high by default
// (RL7) Receive line pulled up by default
// (RL8) Request driven low by default
// (RL9) Clear line pulled down by default
// (RL10) Host tx feeds device rx, and back
// (RL11) Host stops sending when request deasserts
// (RL12) Same port carries script download
// (RL13) Start bit, LSB first, parity, stop
// (RL14) Request drops before receive buffer fills
`timescale 1ns/1ps
module ufc_fifo
	import ufc_pkg::*;
#(
	parameter int WIDTH = FIFO_WIDTH,
	parameter int DEPTH = FIFO_DEPTH
)
(
	input  wire logic                   clk,
	input  wire logic                   reset,
	input  wire logic                   in_valid,
	input  wire logic [WIDTH-1:0]       in_data,
	output logic                        in_ready,
	output logic                        out_valid,
	output logic [WIDTH-1:0]            out_data,
	input  wire logic                   out_ready,
	output logic [$clog2(DEPTH):0]      level
);
	// Pointers wrap naturally, so DEPTH must be a power of two
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic             push;
	logic             pop;

	assign in_ready  = level != (AW+1)'(DEPTH);
	assign out_valid = level != '0;
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (push && !pop)
				level <= level + 1'b1;
			else if (pop && !push)
				level <= level - 1'b1;
		end
	end
endmodule : ufc_fifo

module ufc_device
	import ufc_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 reset,
	ufc_link_if.dev                   link,
	input  wire logic                 parity_en,
	input  wire logic                 parity_odd,
	input  wire logic [DATA_BITS-1:0] tx_data,
	input  wire logic                 tx_valid,
	output logic                      tx_ready,
	output logic [DATA_BITS-1:0]      rx_data,
	output logic                      rx_perr,
	output logic                      rx_valid,
	input  wire logic                 rx_ready,
	output logic                      rx_frame_err,
	output logic                      rx_overrun
);
	logic                 rx_meta;
	logic                 rx_s;
	logic                 cts_meta;
	logic                 cts_n_s;
	logic                 txd;
	logic                 rts_n;
	ufc_state_t           tx_st;
	logic [CNT_W-1:0]     tx_cnt;
	logic [IDX_W-1:0]     tx_idx;
	logic [DATA_BITS-1:0] tx_sh;
	logic                 tx_par;
	ufc_state_t           rx_st;
	logic [CNT_W-1:0]     rx_cnt;
	logic [IDX_W-1:0]     rx_idx;
	logic [DATA_BITS-1:0] rx_sh;
	logic                 rx_pbad;
	logic                 rx_push;
	logic [FIFO_WIDTH-1:0] rx_word;
	logic                 fifo_ready;
	logic [$clog2(FIFO_DEPTH):0] fifo_level;

	assign link.dev_txd = txd;
	assign link.rts_n   = rts_n;

	// Pins cross from the host's timing
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rx_meta  <= 1'b1;
			rx_s     <= 1'b1;
			cts_meta <= 1'b1;
			cts_n_s  <= 1'b1;
		end
		else
		begin
			rx_meta  <= link.rx_line;
			rx_s     <= rx_meta;
			cts_meta <= link.cts_line;
			cts_n_s  <= cts_meta;
		end
	end

	// Transmitter
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			tx_st    <= UFC_IDLE;
			txd      <= 1'b1; // (RL6)
			tx_ready <= 1'b0;
			tx_cnt   <= CNT_ZERO;
			tx_idx   <= IDX_ZERO;
			tx_sh    <= '0;
			tx_par   <= 1'b0;
		end
		else if (tx_st == UFC_IDLE)
		begin
			txd      <= 1'b1; // (RL4)
			tx_ready <= !cts_n_s; // (RL3) (RL5)
			if (tx_valid && tx_ready)
			begin
				tx_sh    <= tx_data;
				tx_par   <= ^tx_data ^ parity_odd;
				txd      <= 1'b0; // (RL13)
				tx_cnt   <= BIT_M1;
				tx_ready <= 1'b0;
				tx_st    <= UFC_START;
			end
		end
		else if (tx_cnt != CNT_ZERO)
			tx_cnt <= tx_cnt - 1'b1;
		else
		begin
			tx_cnt <= BIT_M1;
			unique case (tx_st)
				UFC_START:
				begin
					txd    <= tx_sh[0]; // (RL13)
					tx_sh  <= tx_sh >> 1;
					tx_idx <= IDX_ZERO;
					tx_st  <= UFC_DATA;
				end
				UFC_DATA:
				begin
					if (tx_idx == IDX_LAST)
					begin
						txd   <= parity_en ? tx_par : 1'b1;
						tx_st <= parity_en ? UFC_PAR : UFC_STOP;
					end
					else
					begin
						txd    <= tx_sh[0];
						tx_sh  <= tx_sh >> 1;
						tx_idx <= tx_idx + 1'b1;
					end
				end
				UFC_PAR:
				begin
					txd   <= 1'b1;
					tx_st <= UFC_STOP;
				end
				UFC_STOP:
					tx_st <= UFC_IDLE;
				default:
					tx_st <= UFC_IDLE;
			endcase
		end
	end

	// Receiver, sampling each bit at its middle
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rx_st        <= UFC_IDLE;
			rx_cnt       <= CNT_ZERO;
			rx_idx       <= IDX_ZERO;
			rx_sh        <= '0;
			rx_pbad      <= 1'b0;
			rx_push      <= 1'b0;
			rx_word      <= '0;
			rx_frame_err <= 1'b0;
		end
		else
		begin
			rx_push      <= 1'b0;
			rx_frame_err <= 1'b0;
			if (rx_st == UFC_IDLE)
			begin
				if (!rx_s)
				begin
					rx_cnt <= HALF_M1;
					rx_st  <= UFC_START;
				end
			end
			else if (rx_cnt != CNT_ZERO)
				rx_cnt <= rx_cnt - 1'b1;
			else
			begin
				rx_cnt <= BIT_M1;
				unique case (rx_st)
					UFC_START:
					begin
						// A short low pulse is noise, not a start bit
						rx_st   <= rx_s ? UFC_IDLE : UFC_DATA;
						rx_idx  <= IDX_ZERO;
						rx_pbad <= 1'b0;
					end
					UFC_DATA:
					begin
						rx_sh <= {rx_s, rx_sh[DATA_BITS-1:1]}; // (RL13)
						if (rx_idx == IDX_LAST)
							rx_st <= parity_en ? UFC_PAR : UFC_STOP;
						else
							rx_idx <= rx_idx + 1'b1;
					end
					UFC_PAR:
					begin
						rx_pbad <= rx_s ^ (^rx_sh) ^ parity_odd; // (RL2)
						rx_st   <= UFC_STOP;
					end
					UFC_STOP:
					begin
						rx_st        <= UFC_IDLE;
						rx_push      <= rx_s;
						rx_word      <= {rx_pbad, rx_sh};
						rx_frame_err <= !rx_s;
					end
					default:
						rx_st <= UFC_IDLE;
				endcase
			end
		end
	end

	// Full FIFO drops the character and reports it
	always_ff @(posedge clk)
	begin
		if (reset)
			rx_overrun <= 1'b0;
		else
			rx_overrun <= rx_push && !fifo_ready;
	end

	// Request drops early to absorb characters already in flight
	always_ff @(posedge clk)
	begin
		if (reset)
			rts_n <= 1'b0; // (RL8)
		else
			rts_n <= fifo_level >= RTS_LEVEL; // (RL14) (RL1) (RL3)
	end

	ufc_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.clk       (clk),
		.reset     (reset),
		.in_valid  (rx_push),
		.in_data   (rx_word),
		.in_ready  (fifo_ready),
		.out_valid (rx_valid),
		.out_data  ({rx_perr, rx_data}),
		.out_ready (rx_ready),
		.level     (fifo_level)
	);
endmodule : ufc_device

// *** core/ufc_host.sv ***
/*
 Host end of the serial link: starts characters only while the device requests,
 receives without buffering, drives the clear line.
 Assumes a 50 MHz clock and synchronous reset.
*/
`timescale 1ns/1ps
module ufc_host
	import ufc_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 reset,
	ufc_link_if.host                  link,
	input  wire logic                 parity_en,
	input  wire logic                 parity_odd,
	input  wire logic                 hold_dev,
	input  wire logic [DATA_BITS-1:0] tx_data,
	input  wire logic                 tx_valid,
	output logic                      tx_ready,
	output logic [DATA_BITS-1:0]      rx_data,
	output logic                      rx_perr,
	output logic                      rx_valid
);
	logic                 rx_meta;
	logic                 rx_s;
	logic                 rts_meta;
	logic                 rts_n_s;
	logic                 txd;
	logic                 cts_n;
	ufc_state_t           tx_st;
	logic [CNT_W-1:0]     tx_cnt;
	logic [DATA_BITS:0]   tx_sh;
	logic [IDX_W:0]       tx_left;
	ufc_state_t           rx_st;
	logic [CNT_W-1:0]     rx_cnt;
	logic [IDX_W-1:0]     rx_idx;
	logic [DATA_BITS-1:0] rx_sh;

	assign link.host_txd    = txd;
	assign link.host_txd_oe = 1'b1; // (RL10)
	assign link.cts_n       = cts_n;
	assign link.cts_n_oe    = 1'b1;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rx_meta  <= 1'b1;
			rx_s     <= 1'b1;
			rts_meta <= 1'b1;
			rts_n_s  <= 1'b1;
			cts_n    <= 1'b0;
		end
		else
		begin
			rx_meta  <= link.dev_txd; // (RL10)
			rx_s     <= rx_meta;
			rts_meta <= link.rts_n;
			rts_n_s  <= rts_meta;
			cts_n    <= hold_dev; // (RL5)
		end
	end

	// Data and optional parity shift out as one word
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			tx_st    <= UFC_IDLE;
			txd      <= 1'b1; // (RL4)
			tx_ready <= 1'b0;
			tx_cnt   <= CNT_ZERO;
			tx_sh    <= '0;
			tx_left  <= '0;
		end
		else if (tx_st == UFC_IDLE)
		begin
			txd      <= 1'b1;
			tx_ready <= !rts_n_s; // (RL11)
			if (tx_valid && tx_ready)
			begin
				tx_sh    <= {^tx_data ^ parity_odd, tx_data};
				tx_left  <= (IDX_W+1)'(DATA_BITS) + {IDX_W'(0), parity_en};
				txd      <= 1'b0; // (RL13)
				tx_cnt   <= BIT_M1;
				tx_ready <= 1'b0;
				tx_st    <= UFC_DATA;
			end
		end
		else if (tx_cnt != CNT_ZERO)
			tx_cnt <= tx_cnt - 1'b1;
		else
		begin
			tx_cnt <= BIT_M1;
			if (tx_st == UFC_STOP)
				tx_st <= UFC_IDLE;
			else if (tx_left == '0)
			begin
				txd   <= 1'b1;
				tx_st <= UFC_STOP;
			end
			else
			begin
				txd     <= tx_sh[0]; // (RL13) (RL12)
				tx_sh   <= tx_sh >> 1;
				tx_left <= tx_left - 1'b1;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rx_st    <= UFC_IDLE;
			rx_cnt   <= CNT_ZERO;
			rx_idx   <= IDX_ZERO;
			rx_sh    <= '0;
			rx_data  <= '0;
			rx_perr  <= 1'b0;
			rx_valid <= 1'b0;
		end
		else
		begin
			rx_valid <= 1'b0;
			if (rx_st == UFC_IDLE)
			begin
				if (!rx_s)
				begin
					rx_cnt <= HALF_M1;
					rx_st  <= UFC_START;
				end
			end
			else if (rx_cnt != CNT_ZERO)
				rx_cnt <= rx_cnt - 1'b1;
			else
			begin
				rx_cnt <= BIT_M1;
				unique case (rx_st)
					UFC_START:
					begin
						rx_st   <= rx_s ? UFC_IDLE : UFC_DATA;
						rx_idx  <= IDX_ZERO;
						rx_perr <= 1'b0;
					end
					UFC_DATA:
					begin
						rx_sh <= {rx_s, rx_sh[DATA_BITS-1:1]};
						if (rx_idx == IDX_LAST)
							rx_st <= parity_en ? UFC_PAR : UFC_STOP;
						else
							rx_idx <= rx_idx + 1'b1;
					end
					UFC_PAR:
					begin
						rx_perr <= rx_s ^ (^rx_sh) ^ parity_odd;
						rx_st   <= UFC_STOP;
					end
					UFC_STOP:
					begin
						rx_st    <= UFC_IDLE;
						rx_data  <= rx_sh;
						rx_valid <= rx_s;
					end
					default:
						rx_st <= UFC_IDLE;
				endcase
			end
		end
	end
endmodule : ufc_host

// *** bench/ufc_link_chk.sv ***
/*
 Assertions on the four link wires.
 Assumes tb places it beside the link interface.
*/
`timescale 1ns/1ps
module ufc_link_chk
	import ufc_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic dev_txd,
	input wire logic rts_n,
	input wire logic host_txd,
	input wire logic host_txd_oe,
	input wire logic cts_n,
	input wire logic cts_n_oe,
	input wire logic rx_line,
	input wire logic cts_line
);
	localparam int FMAX = 10 * BIT_CYC;
	logic [15:0] dlo;
	logic [15:0] hlo;
	logic [15:0] dhi;
	logic [15:0] hhi;

	// High runs saturate so a long idle never wraps
	always_ff @(posedge clk)
		dlo <= (reset || dev_txd) ? 16'h0 : dlo + 16'h1;
	always_ff @(posedge clk)
		hlo <= (reset || host_txd) ? 16'h0 : hlo + 16'h1;
	always_ff @(posedge clk)
		dhi <= (reset || !dev_txd) ? 16'h0 : dhi + {15'h0, !dhi[15]};
	always_ff @(posedge clk)
		hhi <= (reset || !host_txd) ? 16'h0 : hhi + {15'h0, !hhi[15]};

	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);

	reset_idle_a:
		assert property ($fell(reset) |-> dev_txd && host_txd && !rts_n)
		else $error("link not idle after reset");
	dev_bits_a:
		assert property ($rose(dev_txd) |->
			dlo % BIT_CYC == 0 && dlo <= FMAX)
		else $error("device low run not whole bits");
	host_bits_a:
		assert property ($rose(host_txd) |->
			hlo % BIT_CYC == 0 && hlo <= FMAX)
		else $error("host low run not whole bits");
	host_drives_a:
		assert property (host_txd_oe && cts_n_oe)
		else $error("host released a line");
	line_pull_a:
		assert property (rx_line == host_txd && cts_line == cts_n)
		else $error("resolved line differs");
	host_obeys_a:
		assert property (rts_n && $past(rts_n, 5) && hhi >= FMAX
			|-> host_txd)
		else $error("host sent while request high");
	dev_obeys_a:
		assert property (cts_line && $past(cts_line, 5) && dhi >= FMAX
			|-> dev_txd)
		else $error("device sent while clear high");
	rts_rise_a:
		assert property ($rose(rts_n) |-> host_txd && $past(host_txd, 3))
		else $error("request rose outside stop bit");
endmodule : ufc_link_chk

// *** bench/tb.sv ***
/*
 Self-checking bench for both link ends and the receive FIFO.
 Assumes the core package, interface and modules compile first.
*/
`timescale 1ns/1ps
module tb;
	logic clk = 1'h0, reset = 1'h1, p_en = 1'h0, d_odd = 1'h0;
	logic h_odd = 1'h0, hold = 1'h0, rx_rdy = 1'h1, d_tv = 1'h0;
	logic h_tv = 1'h0;
	logic d_tr, d_rv, d_perr, d_fe, d_ov, h_tr, h_rv, h_perr;
	logic [7:0] d_td = 8'h00, h_td = 8'h00, d_rd, h_rd;
	logic [8:0] q_d[$], q_h[$];
	int err_count = 0, checks = 0, cyc = 0, n, seed = 32'h41c9;

	ufc_link_if link_i();
	ufc_device ufc_device_i (.clk(clk), .reset(reset), .link(link_i),
		.parity_en(p_en), .parity_odd(d_odd), .tx_data(d_td),
		.tx_valid(d_tv), .tx_ready(d_tr), .rx_data(d_rd), .rx_perr(d_perr),
		.rx_valid(d_rv), .rx_ready(rx_rdy), .rx_frame_err(d_fe),
		.rx_overrun(d_ov));
	ufc_host ufc_host_i (.clk(clk), .reset(reset), .link(link_i),
		.parity_en(p_en), .parity_odd(h_odd), .hold_dev(hold),
		.tx_data(h_td), .tx_valid(h_tv), .tx_ready(h_tr), .rx_data(h_rd),
		.rx_perr(h_perr), .rx_valid(h_rv));
	ufc_link_chk ufc_link_chk_i (.clk(clk), .reset(reset),
		.dev_txd(link_i.dev_txd), .rts_n(link_i.rts_n),
		.host_txd(link_i.host_txd), .host_txd_oe(link_i.host_txd_oe),
		.cts_n(link_i.cts_n), .cts_n_oe(link_i.cts_n_oe),
		.rx_line(link_i.rx_line), .cts_line(link_i.cts_line));

	always #10 clk = ~clk;

	task automatic check(input string what, input logic [8:0] seen, exp);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic close_out();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out

	// Parity flag expected only when the two ends disagree
	task automatic h_send(input logic [7:0] b);
		@(posedge clk);
		h_td <= b;
		h_tv <= 1'h1;
		q_d.push_back({p_en & (d_odd ^ h_odd), b});
		@(posedge clk);
		while (h_tr !== 1'h1) @(posedge clk);
		h_tv <= 1'h0;
	endtask : h_send

	task automatic d_send(input logic [7:0] b);
		@(posedge clk);
		d_td <= b;
		d_tv <= 1'h1;
		q_h.push_back({p_en & (d_odd ^ h_odd), b});
		@(posedge clk);
		while (d_tr !== 1'h1) @(posedge clk);
		d_tv <= 1'h0;
	endtask : d_send

	// Extra idle lets a stop bit finish before settings change
	task automatic drain();
		while (q_d.size() + q_h.size() != 0) @(posedge clk);
		repeat (500) @(posedge clk);
	endtask : drain

	always @(posedge clk)
	begin
		cyc++;
		if (d_rv === 1'h1 && rx_rdy === 1'h1)
		begin
			n++;
			check("dev_rx", {d_perr, d_rd}, q_d.pop_front());
		end
		if (h_rv === 1'h1)
			check("host_rx", {h_perr, h_rd}, q_h.pop_front());
		if (reset === 1'h0 && (d_fe !== 1'h0 || d_ov !== 1'h0))
			check("rx_fault", {d_fe, d_ov}, 9'h000);
		if (cyc == 95000)
		begin
			err_count++;
			close_out();
		end
	end

	initial
	begin
		repeat (10) @(posedge clk);
		reset <= 1'h0;
		repeat (10) @(posedge clk);
		// Full duplex in each parity mode, last one mismatched
		for (int m = 0; m < 4; m++)
		begin
			p_en <= (m != 0);
			d_odd <= (m >= 2);
			h_odd <= (m == 2);
			fork
				h_send(8'($random(seed)));
				d_send(8'($random(seed)));
			join
			drain();
		end
		rx_rdy <= 1'h0;
		fork
			repeat (8) h_send(8'($random(seed)));
		join_none
		while (link_i.rts_n !== 1'h1) @(posedge clk);
		repeat (5000) @(posedge clk);
		check("host_tx_ready", h_tr, 9'h000);
		check("rts_n", link_i.rts_n, 9'h001);
		check("dev_rx_held", d_rv, 9'h001);
		// Random pops drain the held characters unevenly
		repeat (60) @(posedge clk) rx_rdy <= 1'($random(seed));
		@(posedge clk);
		rx_rdy <= 1'h1;
		drain();
		hold <= 1'h1;
		repeat (10) @(posedge clk);
		fork
			d_send(8'hC3);
		join_none
		repeat (5000) @(posedge clk);
		check("dev_tx_ready", d_tr, 9'h000);
		hold <= 1'h0;
		drain();
		// Four mode bytes plus eight flow-control bytes reach the device
		check("dev_pops", 9'(n), 9'h00C);
		check("dev_rx_empty", d_rv, 9'h000);
		close_out();
	end
endmodule : tb
